// ---- led_pwm_driver_28ch.sv ----
// top of the 28-channel led pwm driver: register file, staging, shared pwm counter
// assumes scl, sda and hw_off_n_i synchronous to clk_sys_i; sda wire resolved outside
`timescale 1ns/1ps

// Functional notes
// - soft_off_bit at 00h: 0 means software shutdown, 1 normal run.
// - during software shutdown every channel output is forced off.
// - one 8-bit duty register per channel at 05h to 20h.
// - on-time per period equals duty divided by 256.
// - duty and control writes staged; applied on writing 00h to 25h.
// - control bits 2:1 pick scale: full, half, third, quarter.
// - control bit 0 switches the channel on or off.
// - global register 4Ah bit 0: 0 normal, 1 all leds off.
// - rate register 4Bh bit 0: 0 is 3 kHz, 1 is 22 kHz.
// - writing 00h to 4Fh returns all registers to defaults.
// - power-up reset loads defaults, outputs dark.
// - shutdowns leave register contents unchanged.
// - low hw_off_n pin forces all channel outputs off.
// - all channels share one period counter, turning on together.
// - write-only slave address 01111, strap bits, then write bit 0.
// - byte after address is register pointer, later bytes are data, all acked.
// - pointer advances by one on each data byte acknowledge.
module led_pwm_driver_28ch
  import led_pwm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [1:0] addr_sel_i,
  input wire logic hw_off_n_i,
  output logic [NUM_CH-1:0] channel_outputs_o,
  output logic [2*NUM_CH-1:0] current_scale_o,
  output logic rate_select_bit_o
);

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic [4:0] bank_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] diff;
    diff = a - base;
    bank_index = diff[4:0];
  endfunction : bank_index

  // ==========================================================
  // register state
  reg_write_t wr;
  logic soft_off_bit;
  logic global_off;
  logic rate_select_bit;
  logic [7:0] duty_stage [NUM_CH];
  logic [7:0] duty_live [NUM_CH];
  ch_ctrl_t ctrl_stage [NUM_CH];
  ch_ctrl_t ctrl_live [NUM_CH];
  logic soft_reset;
  logic apply_cmd;
  logic duty_hit;
  logic ctrl_hit;
  logic [4:0] duty_idx;
  logic [4:0] ctrl_idx;

  // ==========================================================
  // serial port
  i2c_write_slave u_i2c (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .addr_sel_i(addr_sel_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .wr_o(wr)
  );

  // ==========================================================
  // write decode
  assign soft_reset = wr.valid && wr.addr == OFS_RESET && wr.data == CMD_VALUE;
  assign apply_cmd = wr.valid && wr.addr == OFS_APPLY && wr.data == CMD_VALUE;
  assign duty_hit = wr.valid && in_range(wr.addr, OFS_DUTY_FIRST, OFS_DUTY_LAST);
  assign ctrl_hit = wr.valid && in_range(wr.addr, OFS_CTRL_FIRST, OFS_CTRL_LAST);
  assign duty_idx = bank_index(wr.addr, OFS_DUTY_FIRST);
  assign ctrl_idx = bank_index(wr.addr, OFS_CTRL_FIRST);

  // ==========================================================
  // single-bit control registers
  // unmapped offsets fall through every branch and change nothing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_off_bit <= RST_BIT;
      global_off <= RST_BIT;
      rate_select_bit <= RST_BIT;
    end else if (soft_reset) begin
      soft_off_bit <= RST_BIT;
      global_off <= RST_BIT;
      rate_select_bit <= RST_BIT;
    end else if (wr.valid) begin
      if (wr.addr == OFS_SHUTDOWN) begin
        soft_off_bit <= wr.data[SOFT_OFF_BIT_POS];
      end
      if (wr.addr == OFS_GLOBAL) begin
        global_off <= wr.data[GLOBAL_OFF_POS];
      end
      if (wr.addr == OFS_RATE) begin
        rate_select_bit <= wr.data[RATE_BIT_POS];
      end
    end
  end

  // ==========================================================
  // staging copies
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_stage[i] <= RST_BYTE;
        ctrl_stage[i] <= '{scale: RST_SCALE, on: RST_BIT};
      end
    end else if (soft_reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_stage[i] <= RST_BYTE;
        ctrl_stage[i] <= '{scale: RST_SCALE, on: RST_BIT};
      end
    end else begin
      if (duty_hit) begin
        duty_stage[duty_idx] <= wr.data;
      end
      if (ctrl_hit) begin
        ctrl_stage[ctrl_idx].scale <= wr.data[SCALE_LSB_POS +: 2];
        ctrl_stage[ctrl_idx].on <= wr.data[CH_ON_POS];
      end
    end
  end

  // ==========================================================
  // applied copies, kept through any shutdown
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_live[i] <= RST_BYTE;
        ctrl_live[i] <= '{scale: RST_SCALE, on: RST_BIT};
      end
    end else if (soft_reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_live[i] <= RST_BYTE;
        ctrl_live[i] <= '{scale: RST_SCALE, on: RST_BIT};
      end
    end else if (apply_cmd) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_live[i] <= duty_stage[i];
        ctrl_live[i] <= ctrl_stage[i];
      end
    end
  end

  // ==========================================================
  // shared period counter
  logic [5:0] slot_div;
  logic [7:0] period_cnt;
  logic [5:0] div_limit;

  assign div_limit = rate_select_bit ? SLOT_DIV_FAST_M1 : SLOT_DIV_SLOW_M1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_div <= 6'h00;
    end else if (slot_div >= div_limit) begin
      slot_div <= 6'h00;
    end else begin
      slot_div <= slot_div + 6'd1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_cnt <= 8'h00;
    end else if (slot_div >= div_limit) begin
      period_cnt <= period_cnt + 8'd1;
    end
  end

  // ==========================================================
  // channel outputs
  logic run_ok;

  assign run_ok = soft_off_bit && !global_off && hw_off_n_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_outputs_o <= '0;
      current_scale_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_outputs_o[i] <= run_ok && ctrl_live[i].on
                                && (period_cnt < duty_live[i]);
        current_scale_o[2*i +: 2] <= ctrl_live[i].scale;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_select_bit_o <= RST_BIT;
    end else begin
      rate_select_bit_o <= rate_select_bit;
    end
  end

endmodule : led_pwm_driver_28ch

// ---- led_pwm_pkg.sv ----
// package for the 28-channel led pwm driver: register map, fields, reset values, timing
// assumes a single 40 mhz system clock
package led_pwm_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NUM_CH = 28;
  localparam int unsigned CLK_HZ = 40_000_000;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_SHUTDOWN = 8'h00;
  localparam logic [7:0] OFS_DUTY_FIRST = 8'h05;
  localparam logic [7:0] OFS_DUTY_LAST = 8'h20;
  localparam logic [7:0] OFS_APPLY = 8'h25;
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h2a;
  localparam logic [7:0] OFS_CTRL_LAST = 8'h45;
  localparam logic [7:0] OFS_GLOBAL = 8'h4a;
  localparam logic [7:0] OFS_RATE = 8'h4b;
  localparam logic [7:0] OFS_RESET = 8'h4f;

  // ==========================================================
  // field positions and command values
  localparam int unsigned SOFT_OFF_BIT_POS = 0;
  localparam int unsigned CH_ON_POS = 0;
  localparam int unsigned SCALE_LSB_POS = 1;
  localparam int unsigned GLOBAL_OFF_POS = 0;
  localparam int unsigned RATE_BIT_POS = 0;
  localparam logic [7:0] CMD_VALUE = 8'h00;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic [1:0] RST_SCALE = 2'b00;

  // ==========================================================
  // i2c slave address
  localparam logic [4:0] ADDR_HIGH = 5'b01111;

  // ==========================================================
  // pwm timing: 256 slots per period
  localparam int unsigned PWM_STEPS = 256;
  localparam int unsigned FREQ_SLOW_HZ = 3_000;
  localparam int unsigned FREQ_FAST_HZ = 22_000;
  localparam int unsigned SLOT_DIV_SLOW = CLK_HZ / (FREQ_SLOW_HZ * PWM_STEPS);
  localparam int unsigned SLOT_DIV_FAST = CLK_HZ / (FREQ_FAST_HZ * PWM_STEPS);
  localparam logic [5:0] SLOT_DIV_SLOW_M1 = 6'(SLOT_DIV_SLOW - 1);
  localparam logic [5:0] SLOT_DIV_FAST_M1 = 6'(SLOT_DIV_FAST - 1);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] scale;
    logic on;
  } ch_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage : led_pwm_pkg

// ---- i2c_write_slave.sv ----
// write-only i2c slave: address match, register pointer, auto increment
// assumes scl and sda inputs already synchronous to clk_sys_i
`timescale 1ns/1ps
module i2c_write_slave
  import led_pwm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] addr_sel_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output reg_write_t wr_o
);

  typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_DATA, ST_IGNORE} i2c_state_t;

  i2c_state_t state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic ack_drive;
  logic [7:0] pointer;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_det = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_det = scl_i & scl_q & ~sda_q & sda_i;

  // ==========================================================
  // edge history
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ==========================================================
  // byte engine
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      shreg <= RST_BYTE;
      bitcnt <= 4'h0;
      ack_drive <= 1'b0;
      pointer <= RST_BYTE;
      wr_o <= '0;
    end else begin
      wr_o.valid <= 1'b0;
      if (start_det) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ack_drive <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
      end else if (state != ST_IDLE && state != ST_IGNORE) begin
        if (scl_rise && bitcnt < 4'd8) begin
          shreg <= {shreg[6:0], sda_i};
          bitcnt <= bitcnt + 4'd1;
        end else if (scl_fall && bitcnt == 4'd8) begin
          bitcnt <= 4'd9;
          unique case (state)
            ST_ADDR: begin
              if (shreg == {ADDR_HIGH, addr_sel_i, 1'b0}) begin
                ack_drive <= 1'b1;
              end else begin
                state <= ST_IGNORE;
              end
            end
            ST_PTR: begin
              pointer <= shreg;
              ack_drive <= 1'b1;
            end
            ST_DATA: begin
              wr_o.valid <= 1'b1;
              wr_o.addr <= pointer;
              wr_o.data <= shreg;
              pointer <= pointer + 8'd1;
              ack_drive <= 1'b1;
            end
            default: begin
              ack_drive <= 1'b0;
            end
          endcase
        end else if (scl_fall && bitcnt == 4'd9) begin
          ack_drive <= 1'b0;
          bitcnt <= 4'h0;
          if (state == ST_ADDR) begin
            state <= ST_PTR;
          end else if (state == ST_PTR) begin
            state <= ST_DATA;
          end
        end
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~ack_drive;

endmodule : i2c_write_slave

// ---- led_pwm_props.sv ----
// checker: port assertions for the 28-channel led pwm driver
// assumes one clock domain; bound to the top module by name
`timescale 1ns/1ps
module led_pwm_props
  import led_pwm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [1:0] addr_sel_i,
  input wire logic hw_off_n_i,
  input wire logic [NUM_CH-1:0] channel_outputs_o,
  input wire logic [2*NUM_CH-1:0] current_scale_o,
  input wire logic rate_select_bit_o
);
  // =====
  // assertions
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_hw_off_dark: assert property (!hw_off_n_i |=> channel_outputs_o == '0)
    else $error("outputs lit during hw shutdown");
  a_sda_pull_only: assert property (sda_o == 1'h0)
    else $error("sda driven high");
  a_ack_scl_low: assert property (!$stable(sda_oe_n_o) |-> !scl_i)
    else $error("ack moved while scl high");
  a_ack_released: assert property ($fell(sda_oe_n_o) |-> ##[1:40] sda_oe_n_o)
    else $error("ack never released");
  a_ack_holds: assert property ($fell(sda_oe_n_o) |-> (!sda_oe_n_o) [*3])
    else $error("ack too short");
  a_reset_dark: assert property ($rose(rst_n_i) |->
    channel_outputs_o == '0 && current_scale_o == '0 && !rate_select_bit_o)
    else $error("outputs not at defaults after reset");
  a_scale_at_write: assert property (!$stable(current_scale_o) |-> !scl_i)
    else $error("scale changed outside a write");
  a_rate_at_write: assert property (!$stable(rate_select_bit_o) |-> !scl_i)
    else $error("rate changed outside a write");
  c_ack: cover property ($fell(sda_oe_n_o));
  c_lit: cover property (|channel_outputs_o);
  c_fast: cover property (rate_select_bit_o);
endmodule : led_pwm_props

bind led_pwm_driver_28ch led_pwm_props u_props (.clk_sys_i, .rst_n_i, .scl_i, .sda_i,
  .sda_o, .sda_oe_n_o, .addr_sel_i, .hw_off_n_i, .channel_outputs_o, .current_scale_o,
  .rate_select_bit_o);

// ---- i2c_host_model.sv ----
// host model: bit-level i2c write master on the system clock
// assumes sda_i is the resolved wire with a pull-up
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o,
  output logic ack_o
);
  // =====
  // bus phases
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
    ack_o = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : hold
  task automatic put_bit(input logic b);
    sda_o <= b;
    hold(4);
    scl_o <= 1'h1;
    hold(4);
    scl_o <= 1'h0;
    hold(2);
  endtask : put_bit
  task automatic start();
    sda_o <= 1'h1;
    hold(4);
    scl_o <= 1'h1;
    hold(4);
    sda_o <= 1'h0;
    hold(4);
    scl_o <= 1'h0;
    hold(2);
  endtask : start
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_o <= 1'h1;
    hold(4);
    scl_o <= 1'h1;
    hold(2);
    ack_o = !sda_i;
    hold(2);
    scl_o <= 1'h0;
    hold(2);
  endtask : put_byte
  task automatic stop();
    sda_o <= 1'h0;
    hold(4);
    scl_o <= 1'h1;
    hold(4);
    sda_o <= 1'h1;
    hold(4);
  endtask : stop
endmodule : i2c_host_model

// ---- tb_top.sv ----
// testbench: i2c writes, pwm counts, shutdowns, reset command
// assumes host model and checker compiled before it
`timescale 1ns/1ps
module tb_top
  import led_pwm_pkg::*;
;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic hw_off_n_i = 1'h1;
  logic [1:0] addr_sel_i = 2'h0;
  logic [NUM_CH-1:0] outs;
  logic [2*NUM_CH-1:0] scales;
  logic rate, scl, m_sda, sda_o, sda_oe_n_o, ack, ok;
  wire sda = m_sda & (sda_oe_n_o | sda_o);
  int num_errors = 0;
  int checks = 0;
  logic [7:0] duty_e [NUM_CH];
  logic [7:0] ctrl_e [NUM_CH];
  logic [7:0] buf_b [NUM_CH];
  logic [7:0] holes [4] = '{8'h01, 8'h21, 8'h46, 8'h4c};

  always #12.5 clk_sys_i = ~clk_sys_i;
  i2c_host_model u_host (.clk_sys_i, .sda_i(sda), .scl_o(scl), .sda_o(m_sda), .ack_o(ack));
  led_pwm_driver_28ch u_led_pwm_driver_28ch (.clk_sys_i, .rst_n_i, .scl_i(scl), .sda_i(sda),
    .sda_o, .sda_oe_n_o, .addr_sel_i, .hw_off_n_i, .channel_outputs_o(outs),
    .current_scale_o(scales), .rate_select_bit_o(rate));

  // =====
  // helpers
  task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  function automatic logic [2*NUM_CH-1:0] exp_scale();
    logic [2*NUM_CH-1:0] s;
    for (int c = 0; c < NUM_CH; c++) s[2*c+:2] = ctrl_e[c][2:1];
    return s;
  endfunction : exp_scale
  task automatic wr(input logic [7:0] p, input int n);
    ok = 1'h1;
    u_host.start();
    u_host.put_byte({ADDR_HIGH, addr_sel_i, 1'h0});
    ok &= ack;
    u_host.put_byte(p);
    ok &= ack;
    for (int i = 0; i < n; i++) begin
      u_host.put_byte(buf_b[i]);
      ok &= ack;
    end
    u_host.stop();
    chk("ack", ok, 1);
  endtask : wr
  task automatic one(input logic [7:0] p, input logic [7:0] v);
    buf_b[0] = v;
    wr(p, 1);
  endtask : one
  task automatic measure(input int div, input bit run);
    logic [31:0] cnt [NUM_CH];
    int rises;
    logic [NUM_CH-1:0] prev;
    rises = 0;
    cnt = '{default: 0};
    repeat (4) @(negedge clk_sys_i);
    prev = outs;
    repeat (256 * div) begin
      @(negedge clk_sys_i);
      for (int c = 0; c < NUM_CH; c++) cnt[c] += outs[c];
      if (|(outs & ~prev)) rises++;
      prev = outs;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      chk("duty", cnt[c], (run && ctrl_e[c][0]) ? duty_e[c] * div : 0);
    end
    chk("rises", rises, run);
    @(posedge clk_sys_i);
  endtask : measure

  // =====
  // tests
  initial begin
    void'($urandom(96));
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    addr_sel_i <= 2'($urandom);
    repeat (2) @(posedge clk_sys_i);
    chk("reset", {outs, scales, rate}, 0);
    for (int i = 0; i < 2; i++) begin
      u_host.start();
      u_host.put_byte({ADDR_HIGH, i ? addr_sel_i : ~addr_sel_i, i[0]});
      chk("nak", ack, 0);
      u_host.stop();
    end
    for (int c = 0; c < NUM_CH; c++) begin
      duty_e[c] = 8'($urandom);
      ctrl_e[c] = 8'($urandom) & 8'h07;
    end
    duty_e[0] = 8'h00;
    ctrl_e[0] = 8'h01;
    duty_e[1] = 8'hff;
    ctrl_e[1] = 8'h07;
    one(OFS_SHUTDOWN, 8'h01);
    buf_b = duty_e;
    wr(OFS_DUTY_FIRST, NUM_CH);
    buf_b = ctrl_e;
    wr(OFS_CTRL_FIRST, NUM_CH);
    one(OFS_APPLY, 8'h01);
    chk("staged", {outs, scales}, 0);
    one(OFS_APPLY, CMD_VALUE);
    chk("scale", scales, exp_scale());
    measure(SLOT_DIV_SLOW, 1);
    one(OFS_RATE, 8'h01);
    chk("rate", rate, 1);
    measure(SLOT_DIV_FAST, 1);
    $display("test staging and rate done");
    for (int i = 0; i < 3; i++) begin
      if (i == 0) hw_off_n_i <= 1'h0;
      else one(i == 1 ? OFS_SHUTDOWN : OFS_GLOBAL, 8'(i - 1));
      measure(SLOT_DIV_FAST, 0);
      hw_off_n_i <= 1'h1;
      one(i == 2 ? OFS_GLOBAL : OFS_SHUTDOWN, 8'(i < 2));
    end
    measure(SLOT_DIV_FAST, 1);
    chk("kept", scales, exp_scale());
    $display("test shutdowns done");
    foreach (holes[i]) one(holes[i], 8'($urandom));
    one(OFS_APPLY, CMD_VALUE);
    chk("holes", {scales, rate}, {exp_scale(), 1'h1});
    measure(SLOT_DIV_FAST, 1);
    $display("test unmapped done");
    one(OFS_RESET, 8'h5a);
    chk("bad cmd", rate, 1);
    one(OFS_RESET, CMD_VALUE);
    chk("defaults", {outs, scales, rate}, 0);
    one(OFS_SHUTDOWN, 8'h01);
    one(OFS_APPLY, CMD_VALUE);
    measure(SLOT_DIV_SLOW, 0);
    $display("test reset command done");
    results();
  end

  initial begin
    repeat (100_000) @(posedge clk_sys_i);
    num_errors++;
    results();
  end
endmodule : tb_top
